// File: src/wlau_consts.svh
// Constants for the word-load address unit.
// Notes on behaviour
// - The address is a base register plus an optional offset taken from a second register or a 5-bit unsigned constant, or a 15-bit constant in the long form.
// - In the short form the unit-side bit picks the data unit and register file of base and offset, 0 for side A and 1 for B; the long form uses file B.
// - In the short form the offset is shifted left by two bits and then added to or subtracted from the base.
// - Pre-increment, pre-decrement, positive and negative offset modes send the computed result to memory.
// - Post-increment and post-decrement modes access memory at the old base and write the updated base back.
// - Arithmetic is linear, except that bases 4 to 7 of either file follow circular mode when the mode register says so.
// - The loaded 32-bit word fills the whole destination, which may lie in either file.
// - The destination-file bit writes the word into file A when zero and file B when one.
// - Base and offset are read and the base is written in the first stage, and the word lands in the fifth stage.
`ifndef WLAU_CONSTS_SVH
`define WLAU_CONSTS_SVH
`define WLAU_WORD_SHIFT   2
`define WLAU_LOAD_STAGES  4
`define WLAU_MODE_NEG     4'h4
`define WLAU_MODE_POS     4'h5
`define WLAU_MODE_PREDEC  4'hC
`define WLAU_MODE_PREINC  4'hD
`define WLAU_MODE_POSTDEC 4'hE
`define WLAU_MODE_POSTINC 4'hF
`define WLAU_CIRC_LO      5'h04
`define WLAU_CIRC_HI      5'h07
`define WLAU_GLOBAL_BASE0 5'h0E
`define WLAU_GLOBAL_BASE1 5'h0F
`define WLAU_AMR_CIRC     2'h1
`endif

// File: src/wlau_pkg.sv
// Types shared by the word-load address unit files.
package wlau_pkg;
   typedef logic [31:0] wlau_word_t;
   typedef logic [4:0]  wlau_reg_t;
   typedef enum logic [1:0] {
      WLAU_IDLE = 2'b00,
      WLAU_BUSY = 2'b01
   } wlau_state_e;
endpackage

// File: src/wlau_wb_if.sv
// Write-back carrier between the address stage and the load return pipe.
`timescale 1ns/1ps
interface wlau_wb_if;
   import wlau_pkg::*;
   logic      issue;
   logic      dst_side;
   wlau_reg_t dst_reg;
   modport src (output issue, output dst_side, output dst_reg);
   modport dst (input issue, input dst_side, input dst_reg);
endinterface

// File: src/wlau_ret_pipe.sv
// Delay line that carries destination tags to the fifth execute stage.
`timescale 1ns/1ps
`include "wlau_consts.svh"
module wlau_ret_pipe
   import wlau_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   wlau_wb_if.dst    tag,
   output logic      valid_o,
   output logic      side_o,
   output wlau_reg_t reg_o
);
   logic [`WLAU_LOAD_STAGES-1:0] v_q;
   logic [`WLAU_LOAD_STAGES-1:0] s_q;
   wlau_reg_t                    r_q [`WLAU_LOAD_STAGES];

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         v_q <= '0;
         s_q <= '0;
         for (int i = 0; i < `WLAU_LOAD_STAGES; i++) r_q[i] <= '0;
      end else begin
         v_q[0] <= tag.issue;
         s_q[0] <= tag.dst_side;
         r_q[0] <= tag.dst_reg;
         for (int i = 1; i < `WLAU_LOAD_STAGES; i++) begin
            v_q[i] <= v_q[i-1];
            s_q[i] <= s_q[i-1];
            r_q[i] <= r_q[i-1];
         end
      end
   end

   assign valid_o = v_q[`WLAU_LOAD_STAGES-1];
   assign side_o  = s_q[`WLAU_LOAD_STAGES-1];
   assign reg_o   = r_q[`WLAU_LOAD_STAGES-1];
endmodule

// File: src/wlau_top.sv
// Word-load address unit: address generation, base write-back and load return.
`timescale 1ns/1ps
`include "wlau_consts.svh"
module wlau_top
   import wlau_pkg::*;
(
   // Clock and reset.
   input  wire logic        MCLK_I,
   input  wire logic        RESET_N_I,
   // Decoded instruction in the first execute stage.
   input  wire logic        ISSUE_I,
   input  wire logic        PRED_TRUE_I,
   input  wire logic        LONG_FORM_I,
   input  wire logic        UNIT_SIDE_I,
   input  wire logic        DST_SIDE_I,
   input  wire logic [4:0]  DST_REG_I,
   input  wire logic [4:0]  BASE_REG_I,
   input  wire logic        OFFSET_IS_CONST_I,
   input  wire logic [4:0]  INDEX_REG_I,
   input  wire logic [4:0]  SHORT_CONST_I,
   input  wire logic [14:0] LONG_CONST_I,
   input  wire logic [3:0]  MODE_I,
   // Register file read data for base and index.
   input  wire logic [31:0] BASE_VAL_I,
   input  wire logic [31:0] INDEX_VAL_I,
   // Addressing mode register contents.
   input  wire logic [31:0] AMR_I,
   // Data memory return.
   input  wire logic [31:0] MEM_RDATA_I,
   // Register file read selects.
   output logic             RD_SIDE_O,
   output logic [4:0]       RD_BASE_O,
   output logic [4:0]       RD_INDEX_O,
   // Data memory request.
   output logic             MEM_REQ_O,
   output logic [31:0]      MEM_ADDR_O,
   // Base write-back.
   output logic             BASE_WE_O,
   output logic             BASE_SIDE_O,
   output logic [4:0]       BASE_REG_O,
   output logic [31:0]      BASE_WDATA_O,
   // Destination write.
   output logic             DST_WE_A_O,
   output logic             DST_WE_B_O,
   output logic [4:0]       DST_REG_O,
   output logic [31:0]      DST_WDATA_O,
   // Unit state.
   output logic             BUSY_O
);
   // ********************************************************
   // Address arithmetic
   // ********************************************************
   // Circular mode select from the mode register, two bits per base register.
   function automatic logic circ_sel(input logic side, input wlau_reg_t r, input logic [31:0] addressing_mode_register);
      logic [3:0] idx;
      idx = {side, r[1:0], 1'b0};
      circ_sel = (r >= `WLAU_CIRC_LO) && (r <= `WLAU_CIRC_HI) &&
                 (addressing_mode_register[idx +: 2] == `WLAU_AMR_CIRC);
   endfunction

   function automatic wlau_word_t circ_apply(input wlau_word_t base, input wlau_word_t res,
                                             input logic side, input logic [31:0] addressing_mode_register);
      logic [4:0]  bk;
      wlau_word_t  msk;
      bk  = side ? addressing_mode_register[25:21] : addressing_mode_register[20:16];
      msk = (32'h0000_0002 << bk) - 32'h0000_0001;
      circ_apply = (base & ~msk) | (res & msk);
   endfunction

   logic       side;
   wlau_reg_t  base_reg;
   wlau_word_t offs;
   wlau_word_t sum;
   wlau_word_t newb;
   logic       sub;
   logic       post;
   logic       wb;
   logic       go;

   always_comb begin
      go       = ISSUE_I && PRED_TRUE_I;
      side     = LONG_FORM_I ? 1'b1 : UNIT_SIDE_I;
      base_reg = LONG_FORM_I ? (UNIT_SIDE_I ? `WLAU_GLOBAL_BASE1 : `WLAU_GLOBAL_BASE0)
                             : BASE_REG_I;
      if (LONG_FORM_I)
         offs = {15'h0000, LONG_CONST_I, 2'h0};
      else if (OFFSET_IS_CONST_I)
         offs = {25'h0000000, SHORT_CONST_I, 2'h0};
      else
         offs = {INDEX_VAL_I[29:0], 2'h0};
      sub  = !LONG_FORM_I && ((MODE_I == `WLAU_MODE_NEG) || (MODE_I == `WLAU_MODE_PREDEC) ||
                              (MODE_I == `WLAU_MODE_POSTDEC));
      post = !LONG_FORM_I && ((MODE_I == `WLAU_MODE_POSTINC) || (MODE_I == `WLAU_MODE_POSTDEC));
      wb   = !LONG_FORM_I && (post || (MODE_I == `WLAU_MODE_PREINC) ||
                              (MODE_I == `WLAU_MODE_PREDEC));
      sum  = sub ? BASE_VAL_I - offs : BASE_VAL_I + offs;
      if (!LONG_FORM_I && circ_sel(side, base_reg, AMR_I))
         newb = circ_apply(BASE_VAL_I, sum, side, AMR_I);
      else
         newb = sum;
   end

   // ********************************************************
   // First stage: read selects, memory request, base update
   // ********************************************************
   always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         RD_SIDE_O  <= 1'b0;
         RD_BASE_O  <= '0;
         RD_INDEX_O <= '0;
      end else begin
         RD_SIDE_O  <= side;
         RD_BASE_O  <= base_reg;
         RD_INDEX_O <= INDEX_REG_I;
      end
   end

   always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         MEM_REQ_O  <= 1'b0;
         MEM_ADDR_O <= '0;
      end else begin
         MEM_REQ_O  <= go;
         MEM_ADDR_O <= post ? BASE_VAL_I : newb;
      end
   end

   always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         BASE_WE_O    <= 1'b0;
         BASE_SIDE_O  <= 1'b0;
         BASE_REG_O   <= '0;
         BASE_WDATA_O <= '0;
      end else begin
         BASE_WE_O    <= go && wb;
         BASE_SIDE_O  <= side;
         BASE_REG_O   <= base_reg;
         BASE_WDATA_O <= newb;
      end
   end

   // ********************************************************
   // Load return to the fifth stage
   // ********************************************************
   wlau_wb_if tag ();
   assign tag.issue    = go;
   assign tag.dst_side = DST_SIDE_I;
   assign tag.dst_reg  = DST_REG_I;

   logic      ret_v;
   logic      ret_s;
   wlau_reg_t ret_r;

   // Four stages of tag delay align with memory data returning in stage five.
   wlau_ret_pipe u_ret (
      .clk_i   (MCLK_I),
      .rst_n_i (RESET_N_I),
      .tag     (tag),
      .valid_o (ret_v),
      .side_o  (ret_s),
      .reg_o   (ret_r)
   );

   always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         DST_WE_A_O  <= 1'b0;
         DST_WE_B_O  <= 1'b0;
         DST_REG_O   <= '0;
         DST_WDATA_O <= '0;
      end else begin
         DST_WE_A_O  <= ret_v && !ret_s;
         DST_WE_B_O  <= ret_v && ret_s;
         DST_REG_O   <= ret_r;
         DST_WDATA_O <= MEM_RDATA_I;
      end
   end

   wlau_state_e state_q;
   always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         state_q <= WLAU_IDLE;
         BUSY_O  <= 1'b0;
      end else begin
         unique case (state_q)
            WLAU_IDLE: state_q <= go ? WLAU_BUSY : WLAU_IDLE;
            WLAU_BUSY: state_q <= (go || tag.issue) ? WLAU_BUSY : WLAU_IDLE;
         endcase
         BUSY_O <= go;
      end
   end
endmodule

// File: dv/wlau_mem_mdl.sv
// Data memory model that answers each word load four edges after issue.
`timescale 1ns/1ps
module wlau_mem_mdl (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        req_i,
   input  wire logic [31:0] addr_i,
   output logic      [31:0] rdata_o
);
   logic [1:0]  vld_q;
   logic [31:0] a0_q;
   logic [31:0] a1_q;
   // Between answers the bus inverts its value on each edge, so the last answered word shows again on every second edge.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         vld_q <= 2'h0;
         a0_q <= 32'h0;
         a1_q <= 32'h0;
         rdata_o <= 32'h0;
      end else begin
         vld_q <= {vld_q[0], req_i};
         a0_q <= addr_i;
         a1_q <= a0_q;
         rdata_o <= vld_q[1] ? (a1_q ^ 32'hA5C3_0F96) : ~rdata_o;
      end
   end
endmodule

// File: dv/wlau_chk_sva.sv
// Port checker for the word-load address unit.
`timescale 1ns/1ps
`include "wlau_consts.svh"
module wlau_chk (
   input wire logic        MCLK_I,
   input wire logic        RESET_N_I,
   input wire logic        ISSUE_I,
   input wire logic        PRED_TRUE_I,
   input wire logic        LONG_FORM_I,
   input wire logic        DST_SIDE_I,
   input wire logic        OFFSET_IS_CONST_I,
   input wire logic [4:0]  SHORT_CONST_I,
   input wire logic [14:0] LONG_CONST_I,
   input wire logic [3:0]  MODE_I,
   input wire logic [31:0] BASE_VAL_I,
   input wire logic [31:0] AMR_I,
   input wire logic [31:0] MEM_RDATA_I,
   input wire logic        MEM_REQ_O,
   input wire logic [31:0] MEM_ADDR_O,
   input wire logic        BASE_WE_O,
   input wire logic [31:0] BASE_WDATA_O,
   input wire logic        DST_WE_A_O,
   input wire logic        DST_WE_B_O,
   input wire logic [31:0] DST_WDATA_O
);
   default clocking @(posedge MCLK_I); endclocking
   default disable iff (!RESET_N_I);
   wire        go   = ISSUE_I && PRED_TRUE_I;
   wire        lin  = go && !LONG_FORM_I && OFFSET_IS_CONST_I && AMR_I == 32'h0;
   wire [31:0] ssum = BASE_VAL_I + {25'h0, SHORT_CONST_I, 2'h0};
   wire [31:0] sdif = BASE_VAL_I - {25'h0, SHORT_CONST_I, 2'h0};
   wire [31:0] lsum = BASE_VAL_I + {15'h0, LONG_CONST_I, 2'h0};
   req_issue_a: assert property (go |=> MEM_REQ_O) else $error("no request after issue");
   pred_off_a: assert property (!go |=> !MEM_REQ_O && !BASE_WE_O) else $error("stray access");
   dst_lat_a: assert property (go |-> ##5 (DST_WE_A_O || DST_WE_B_O)) else $error("late load");
   dst_file_a: assert property (go |-> ##5 DST_WE_B_O == $past(DST_SIDE_I, 5)) else $error("bad file");
   dst_word_a: assert property (DST_WE_A_O || DST_WE_B_O |-> DST_WDATA_O == $past(MEM_RDATA_I))
      else $error("bad word");
   long_add_a: assert property (go && LONG_FORM_I |=> !BASE_WE_O && MEM_ADDR_O == $past(lsum))
      else $error("bad long address");
   post_addr_a: assert property (lin && MODE_I[3:1] == 3'h7 |=> MEM_ADDR_O == $past(BASE_VAL_I) && BASE_WE_O)
      else $error("bad post address");
   pos_addr_a: assert property (lin && MODE_I == `WLAU_MODE_POS |=> MEM_ADDR_O == $past(ssum) && !BASE_WE_O)
      else $error("bad offset address");
   predec_a: assert property (lin && MODE_I == `WLAU_MODE_PREDEC |=>
      MEM_ADDR_O == $past(sdif) && BASE_WDATA_O == $past(sdif))
      else $error("bad predecrement");
   cover property (go && LONG_FORM_I);
   cover property (lin && MODE_I == `WLAU_MODE_POSTINC);
   cover property (DST_WE_B_O);
endmodule
bind wlau_top wlau_chk u_chk (.MCLK_I, .RESET_N_I, .ISSUE_I, .PRED_TRUE_I, .LONG_FORM_I, .DST_SIDE_I,
   .OFFSET_IS_CONST_I, .SHORT_CONST_I, .LONG_CONST_I, .MODE_I, .BASE_VAL_I, .AMR_I, .MEM_RDATA_I,
   .MEM_REQ_O, .MEM_ADDR_O, .BASE_WE_O, .BASE_WDATA_O, .DST_WE_A_O, .DST_WE_B_O, .DST_WDATA_O);

// File: dv/tb_word_load_address_unit.sv
// Self-checking testbench for the word-load address unit.
`timescale 1ns/1ps
`include "wlau_consts.svh"
module tb_word_load_address_unit;
   logic        MCLK_I, RESET_N_I, ISSUE_I, PRED_TRUE_I, LONG_FORM_I, UNIT_SIDE_I, DST_SIDE_I, OFFSET_IS_CONST_I;
   logic [4:0]  DST_REG_I, BASE_REG_I, INDEX_REG_I, SHORT_CONST_I, RD_BASE_O, RD_INDEX_O, BASE_REG_O, DST_REG_O;
   logic [14:0] LONG_CONST_I;
   logic [3:0]  MODE_I;
   logic [31:0] BASE_VAL_I, INDEX_VAL_I, AMR_I, MEM_RDATA_I, MEM_ADDR_O, BASE_WDATA_O, DST_WDATA_O;
   logic        RD_SIDE_O, MEM_REQ_O, BASE_WE_O, BASE_SIDE_O, DST_WE_A_O, DST_WE_B_O, BUSY_O;
   int          bad_count = 0;
   int          tests_run = 0;
   localparam logic [3:0] MODES [6] = '{`WLAU_MODE_NEG, `WLAU_MODE_POS, `WLAU_MODE_PREDEC,
                                        `WLAU_MODE_PREINC, `WLAU_MODE_POSTDEC, `WLAU_MODE_POSTINC};
   wlau_top dut (.*);
   wlau_mem_mdl mem (.clk_i(MCLK_I), .rst_n_i(RESET_N_I), .req_i(MEM_REQ_O), .addr_i(MEM_ADDR_O), .rdata_o(MEM_RDATA_I));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic finish_test;
      $display("Checks %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // One load: flags, base and const, long const, mode, base/index/mode-register values, expected results.
   task automatic run(input logic l, y, s, c, p, input logic [4:0] r, k, input logic [14:0] q, input logic [3:0] m,
                      input logic [31:0] b, x, a, ea, input logic ewe, input logic [31:0] ewb);
      @(negedge MCLK_I);
      {ISSUE_I, PRED_TRUE_I, LONG_FORM_I, UNIT_SIDE_I, DST_SIDE_I, OFFSET_IS_CONST_I} = {1'b1, p, l, y, s, c};
      {BASE_REG_I, SHORT_CONST_I, LONG_CONST_I, MODE_I, BASE_VAL_I, INDEX_VAL_I, AMR_I} = {r, k, q, m, b, x, a};
      @(negedge MCLK_I);
      ISSUE_I = 1'b0;
      chk(32'(MEM_REQ_O), 32'(p));
      chk(32'(RD_SIDE_O), 32'(y | l));
      chk(32'(RD_BASE_O), 32'(l ? (y ? `WLAU_GLOBAL_BASE1 : `WLAU_GLOBAL_BASE0) : r));
      chk(32'(BASE_REG_O), 32'(l ? (y ? `WLAU_GLOBAL_BASE1 : `WLAU_GLOBAL_BASE0) : r));
      chk(32'(BASE_SIDE_O), 32'(y | l));
      chk(32'(RD_INDEX_O), 32'h0);
      chk(32'(BUSY_O), 32'(p));
      if (p) chk(MEM_ADDR_O, ea);
      chk(32'(BASE_WE_O), 32'(ewe & p));
      if (ewe & p) chk(BASE_WDATA_O, ewb);
      repeat (4) @(negedge MCLK_I);
      chk(32'({DST_WE_B_O, DST_WE_A_O}), p ? (s ? 32'h2 : 32'h1) : 32'h0);
      if (p) chk(DST_WDATA_O, ea ^ 32'hA5C3_0F96);
      if (p) chk(32'(DST_REG_O), 32'h9);
   endtask
   task automatic t_modes;
      logic [31:0] cv;
      for (int i = 0; i < 6; i++) begin
         cv = MODES[i][0] ? 32'h0000_200C : 32'h0000_1FF4;
         run(0, 0, i[0], 1, 1, 5'h01, 5'h03, 15'h0, MODES[i], 32'h0000_2000, 32'h0, 32'h0,
             (MODES[i][3:1] == 3'h7) ? 32'h0000_2000 : cv, MODES[i][3], cv);
      end
   endtask
   task automatic t_other;
      run(0, 1, 0, 0, 1, 5'h02, 5'h1F, 15'h0, `WLAU_MODE_POS, 32'h8000_0000, 32'h10, 32'h0, 32'h8000_0040, 0, 0);
      for (int y = 0; y < 2; y++) begin
         run(1, y, 1, 1, 1, 5'h01, 5'h00, 15'h7FFF, `WLAU_MODE_POSTINC, 32'h0001_0000, 32'h0, 32'h0003_FFFF,
             32'h0002_FFFC, 0, 0);
      end
      run(0, 0, 1, 1, 0, 5'h01, 5'h03, 15'h0, `WLAU_MODE_POSTINC, 32'h0000_2000, 32'h0, 32'h0, 0, 1, 0);
      run(0, 0, 0, 1, 1, 5'h04, 5'h02, 15'h0, `WLAU_MODE_POSTINC, 32'h0000_100C, 32'h0, 32'h0003_0001,
          32'h0000_100C, 1, 32'h0000_1004);
   endtask
   initial begin
      MCLK_I = 1'b0;
      forever #5 MCLK_I = ~MCLK_I;
   end
   initial begin
      #20000;
      bad_count++;
      finish_test();
   end
   // Every address used is word aligned and the reserved bit has no port.
   initial begin
      {RESET_N_I, ISSUE_I, PRED_TRUE_I, LONG_FORM_I, UNIT_SIDE_I, DST_SIDE_I, OFFSET_IS_CONST_I} = 7'h0;
      {DST_REG_I, BASE_REG_I, INDEX_REG_I, SHORT_CONST_I, LONG_CONST_I, MODE_I} = {5'h09, 34'h0};
      {BASE_VAL_I, INDEX_VAL_I, AMR_I} = 96'h0;
      repeat (6) @(negedge MCLK_I);
      RESET_N_I = 1'b1;
      t_modes();
      t_other();
      finish_test();
   end
endmodule
